// file: verilog/ams_cfg.svh
// Register map, field positions, reset values and timing figures of the monitor sequencer
`ifndef AMS_CFG_SVH
`define AMS_CFG_SVH

// Register indices; byte address on the bus is four times the index
`define AMS_IDX_CFG_ONE    8'h00
`define AMS_IDX_CFG_TWO    8'h01
`define AMS_IDX_CFG_FOUR   8'h03
`define AMS_IDX_PIN_MODE   8'h04
`define AMS_IDX_FORMAT     8'h05
`define AMS_IDX_LOW_ONE    8'h08
`define AMS_IDX_LOW_TWO    8'h09
`define AMS_IDX_ANALOG_INPUT_ONE_VAL   8'h0A
`define AMS_IDX_ANALOG_INPUT_TWO_VAL   8'h0B
`define AMS_IDX_SUPPLY_VAL 8'h0C
`define AMS_IDX_REM1_VAL   8'h0D
`define AMS_IDX_LOCAL_VAL  8'h0E

// Field positions
`define AMS_BIT_START      0
`define AMS_BIT_TH_10K     0
`define AMS_BIT_AVG_OFF    4
`define AMS_BIT_SINGLE     3
`define AMS_SEL_MSB        2
`define AMS_BIT_PIN_TH1    0
`define AMS_BIT_PIN_TH2    1
`define AMS_BIT_PIN_DIODE2 2
`define AMS_BIT_FMT_OFFSET 0

// Reset values
`define AMS_RST_CFG        8'h00
`define AMS_RST_VALUE      10'h000

// Averaging and formatting
`define AMS_AVG_SAMPLES    5'h10
`define AMS_AVG_SHIFT      4
`define AMS_OFFSET_BINARY  10'h100

// Clock rate and per-channel worst-case times in milliseconds
`define AMS_CLK_HZ         25.0e6
`define AMS_T_LOC_ON_MS    8.99
`define AMS_T_REM_ON_MS    36.69
`define AMS_T_AIN_ON_MS    8.65
`define AMS_T_VCC_ON_MS    8.26
`define AMS_T_LOC_OFF_MS   1.36
`define AMS_T_REM_OFF_MS   6.25
`define AMS_T_AIN_OFF_MS   1.02
`define AMS_T_VCC_OFF_MS   0.61
`define AMS_T_SINGLE_MS    1.4
`define AMS_MS_TO_CYC(ms)  $rtoi((ms) * 1.0e-3 * `AMS_CLK_HZ)

`endif

// file: verilog/ams_pkg.sv
// Types shared by the monitor sequencer
`default_nettype none
package ams_pkg;

  // Converter channels, coded as the single-channel select field
  typedef enum logic [2:0] {
    CH_ANALOG_INPUT_ONE   = 3'h0,
    CH_ANALOG_INPUT_TWO   = 3'h1,
    CH_SUPPLY = 3'h2,
    CH_REM1   = 3'h3,
    CH_LOCAL  = 3'h4,
    CH_REM2   = 3'h5
  } ams_chan_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_REQ  = 2'h1,
    ST_WAIT = 2'h2,
    ST_HOLD = 2'h3
  } ams_state_t;

  // A stored result: eight whole-degree bits and two quarter-degree bits
  typedef struct packed {
    logic [7:0] msb;
    logic [1:0] lsb;
  } ams_result_t;

endpackage : ams_pkg
`default_nettype wire

// file: verilog/ams_sequencer.sv
// Measurement sequencer with Wishbone register file for a monitoring converter
`include "ams_cfg.svh"
`default_nettype none
module ams_sequencer #(
  parameter int unsigned T_LOC_ON_CYC   = `AMS_MS_TO_CYC(`AMS_T_LOC_ON_MS),
  parameter int unsigned T_REM_ON_CYC   = `AMS_MS_TO_CYC(`AMS_T_REM_ON_MS),
  parameter int unsigned T_AIN_ON_CYC   = `AMS_MS_TO_CYC(`AMS_T_AIN_ON_MS),
  parameter int unsigned T_VCC_ON_CYC   = `AMS_MS_TO_CYC(`AMS_T_VCC_ON_MS),
  parameter int unsigned T_LOC_OFF_CYC  = `AMS_MS_TO_CYC(`AMS_T_LOC_OFF_MS),
  parameter int unsigned T_REM_OFF_CYC  = `AMS_MS_TO_CYC(`AMS_T_REM_OFF_MS),
  parameter int unsigned T_AIN_OFF_CYC  = `AMS_MS_TO_CYC(`AMS_T_AIN_OFF_MS),
  parameter int unsigned T_VCC_OFF_CYC  = `AMS_MS_TO_CYC(`AMS_T_VCC_OFF_MS),
  parameter int unsigned T_SINGLE_CYC   = `AMS_MS_TO_CYC(`AMS_T_SINGLE_MS),
  parameter logic [7:0]  TH100K_GAIN    = 8'h40,
  parameter logic [9:0]  TH100K_OFFSET  = 10'h000,
  parameter logic [7:0]  TH10K_GAIN     = 8'h40,
  parameter logic [9:0]  TH10K_OFFSET   = 10'h000
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone classic slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [11:0]        adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  // Converter front end
  output logic                    adc_req_o,
  output ams_pkg::ams_chan_t      adc_chan_o,
  input  wire logic               adc_ack_i,
  input  wire logic [9:0]         adc_data_i,
  output logic                    busy_o
);

  localparam int unsigned TW = 20;

  // Configuration registers
  logic [7:0]           cfg_one_reg;
  logic [7:0]           cfg_two_reg;
  logic [7:0]           cfg_four_reg;
  logic [7:0]           pin_mode_reg;
  logic [7:0]           format_reg;

  // Sequencer state
  ams_pkg::ams_state_t  state_reg;
  ams_pkg::ams_state_t  state_next;
  ams_pkg::ams_chan_t   chan_reg;
  ams_pkg::ams_chan_t   chan_next;
  logic [TW-1:0]        timer_reg;
  logic [13:0]          sum_reg;
  logic [4:0]           count_reg;
  logic                 req_reg;
  logic                 single_q_reg;

  // Results: live copy and bus-visible copy
  ams_pkg::ams_result_t res_reg [5];
  ams_pkg::ams_result_t vis_reg [5];
  logic                 freeze_reg;
  logic [3:0]           read_mask_reg;

  logic                 ack_reg;
  logic [31:0]          dat_reg;

  // Bus decode
  wire        bus_req    = cyc_i & stb_i;
  wire [7:0]  idx        = adr_i[9:2];
  wire        wr_now     = bus_req & ack_reg & we_i & sel_i[0] & (adr_i[11:10] == 2'h0);
  wire        rd_now     = bus_req & ack_reg & ~we_i & (adr_i[11:10] == 2'h0);

  // Mode decode
  wire        run        = cfg_one_reg[`AMS_BIT_START];
  wire        single     = cfg_four_reg[`AMS_BIT_SINGLE];
  wire [2:0]  single_sel = cfg_four_reg[`AMS_SEL_MSB:0];
  wire        diode2     = pin_mode_reg[`AMS_BIT_PIN_DIODE2];
  wire        avg_off    = cfg_two_reg[`AMS_BIT_AVG_OFF];
  wire        th_10k     = cfg_two_reg[`AMS_BIT_TH_10K];
  wire        fmt_offset = format_reg[`AMS_BIT_FMT_OFFSET];
  // A sample still in flight holds off the restart, so requests never overlap
  wire        sample_open  = (state_reg == ams_pkg::ST_REQ) |
                             ((state_reg == ams_pkg::ST_WAIT) & ~adc_ack_i);
  wire        leave_single = single_q_reg & ~single & run & ~sample_open;

  // Select values beyond the table fall back to input one
  wire ams_pkg::ams_chan_t sel_chan =
    (single_sel > 3'h5) ? ams_pkg::CH_ANALOG_INPUT_ONE : ams_pkg::ams_chan_t'(single_sel);

  wire ams_pkg::ams_chan_t first_chan =
    diode2 ? ams_pkg::CH_REM2 : ams_pkg::CH_ANALOG_INPUT_ONE;

  // Round-robin successor; second diode takes one slot in place of both analog input slots
  function automatic ams_pkg::ams_chan_t rr_next(input ams_pkg::ams_chan_t c,
                                                 input logic d2);
    case (c)
      ams_pkg::CH_ANALOG_INPUT_ONE:   rr_next = ams_pkg::CH_ANALOG_INPUT_TWO;
      ams_pkg::CH_ANALOG_INPUT_TWO:   rr_next = ams_pkg::CH_SUPPLY;
      ams_pkg::CH_SUPPLY: rr_next = ams_pkg::CH_REM1;
      ams_pkg::CH_REM1:   rr_next = ams_pkg::CH_LOCAL;
      ams_pkg::CH_LOCAL:  rr_next = d2 ? ams_pkg::CH_REM2 : ams_pkg::CH_ANALOG_INPUT_ONE;
      ams_pkg::CH_REM2:   rr_next = ams_pkg::CH_SUPPLY;
      default:            rr_next = ams_pkg::CH_ANALOG_INPUT_ONE;
    endcase
  endfunction : rr_next

  // Slot length per channel; the slot bounds each conversion pass
  function automatic logic [TW-1:0] slot_len(input ams_pkg::ams_chan_t c,
                                             input logic off, input logic sgl);
    int unsigned t;
    t = T_AIN_ON_CYC;
    if (sgl)
      t = T_SINGLE_CYC;
    else
      case (c)
        ams_pkg::CH_LOCAL:  t = off ? T_LOC_OFF_CYC : T_LOC_ON_CYC;
        ams_pkg::CH_REM1,
        ams_pkg::CH_REM2:   t = off ? T_REM_OFF_CYC : T_REM_ON_CYC;
        ams_pkg::CH_SUPPLY: t = off ? T_VCC_OFF_CYC : T_VCC_ON_CYC;
        default:            t = off ? T_AIN_OFF_CYC : T_AIN_ON_CYC;
      endcase
    if (t == 0)
      t = 1;
    slot_len = TW'(t - 1);
  endfunction : slot_len

  // Sample handling
  wire        need_one   = avg_off;
  wire [4:0]  need       = need_one ? 5'h01 : `AMS_AVG_SAMPLES;
  wire [13:0] sum_add    = sum_reg + {4'h0, adc_data_i};
  wire [4:0]  count_add  = count_reg + 5'h01;
  wire        last_samp  = (count_add == need);
  wire [9:0]  averaged   = need_one ? sum_reg[9:0] : sum_reg[13:`AMS_AVG_SHIFT];
  wire        slot_done  = (timer_reg >= slot_len(chan_reg, avg_off, single));

  // Thermistor scaling to quarter-degree code weight
  wire        is_th      = ~diode2 &
                           (((chan_reg == ams_pkg::CH_ANALOG_INPUT_ONE) & pin_mode_reg[`AMS_BIT_PIN_TH1]) |
                            ((chan_reg == ams_pkg::CH_ANALOG_INPUT_TWO) & pin_mode_reg[`AMS_BIT_PIN_TH2]));
  wire [7:0]  th_gain    = th_10k ? TH10K_GAIN : TH100K_GAIN;
  wire [9:0]  th_off     = th_10k ? TH10K_OFFSET : TH100K_OFFSET;
  wire [17:0] th_prod    = averaged * th_gain;
  wire [12:0] th_sum     = {1'b0, th_prod[17:6]} + {3'h0, th_off};
  wire [9:0]  th_val     = (th_sum[12:10] != 3'h0) ? 10'h3FF : th_sum[9:0];

  // Offset-binary applies to every temperature channel, saturating at full scale
  wire        is_temp    = is_th | (chan_reg == ams_pkg::CH_REM1) |
                           (chan_reg == ams_pkg::CH_LOCAL) | (chan_reg == ams_pkg::CH_REM2);
  wire [9:0]  base_val   = is_th ? th_val : averaged;
  wire [10:0] ofs_sum    = {1'b0, base_val} + {1'b0, `AMS_OFFSET_BINARY};
  wire [9:0]  final_val  = (fmt_offset & is_temp) ?
                           (ofs_sum[10] ? 10'h3FF : ofs_sum[9:0]) : base_val;

  // Second diode shares the input-one value register
  wire [2:0]  dest       = (chan_reg == ams_pkg::CH_REM2) ? 3'h0 : 3'(chan_reg);
  wire        commit     = (state_reg == ams_pkg::ST_HOLD) & slot_done & run & ~leave_single;

  // Next channel after a slot
  wire ams_pkg::ams_chan_t after_slot =
    single ? sel_chan : rr_next(chan_reg, diode2);

  // Sequencer state machine
  always_comb
  begin
    state_next = state_reg;
    chan_next  = chan_reg;
    case (state_reg)
      ams_pkg::ST_IDLE:
      begin
        if (run)
        begin
          state_next = ams_pkg::ST_REQ;
          chan_next  = single ? sel_chan : first_chan;
        end
      end
      ams_pkg::ST_REQ:
        state_next = ams_pkg::ST_WAIT;
      ams_pkg::ST_WAIT:
      begin
        if (adc_ack_i)
          state_next = last_samp ? ams_pkg::ST_HOLD : ams_pkg::ST_REQ;
      end
      ams_pkg::ST_HOLD:
      begin
        if (slot_done)
        begin
          state_next = ams_pkg::ST_REQ;
          chan_next  = after_slot;
        end
      end
      default:
        state_next = ams_pkg::ST_IDLE;
    endcase
    if (!run)
      state_next = ams_pkg::ST_IDLE;
    else if (leave_single)
    begin
      state_next = ams_pkg::ST_REQ;
      chan_next  = first_chan;
    end
  end

  wire slot_start = (state_next == ams_pkg::ST_REQ) &
                    ((state_reg == ams_pkg::ST_IDLE) | (state_reg == ams_pkg::ST_HOLD) |
                     leave_single);

  // Sequencer registers; a slot start clears the timer, sample sum and count
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg    <= ams_pkg::ST_IDLE;
      chan_reg     <= ams_pkg::CH_ANALOG_INPUT_ONE;
      timer_reg    <= '0;
      sum_reg      <= '0;
      count_reg    <= '0;
      req_reg      <= 1'b0;
      single_q_reg <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      chan_reg     <= chan_next;
      if (!sample_open)
        single_q_reg <= single;
      req_reg      <= (state_next == ams_pkg::ST_REQ);
      if (slot_start)
      begin
        timer_reg <= '0;
        sum_reg   <= '0;
        count_reg <= '0;
      end
      else
      begin
        if (timer_reg != {TW{1'b1}})
          timer_reg <= timer_reg + TW'(1);
        if ((state_reg == ams_pkg::ST_WAIT) & adc_ack_i)
        begin
          sum_reg   <= sum_add;
          count_reg <= count_add;
        end
      end
    end
  end

  // Live results: each finished slot overwrites its channel's value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 5; i++)
        res_reg[i] <= `AMS_RST_VALUE;
    end
    else if (commit)
      res_reg[dest] <= final_val;
  end

  // Frozen-read tracking: a low-bits read pins the remote-one and local registers
  wire       hit_low1 = rd_now & (idx == `AMS_IDX_LOW_ONE);
  wire       hit_low2 = rd_now & (idx == `AMS_IDX_LOW_TWO);
  wire       hit_rem  = rd_now & (idx == `AMS_IDX_REM1_VAL);
  wire       hit_loc  = rd_now & (idx == `AMS_IDX_LOCAL_VAL);
  wire [3:0] mask_add = read_mask_reg | {hit_loc, hit_rem, hit_low2, hit_low1};
  wire       all_read = (mask_add == 4'hF);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      freeze_reg    <= 1'b0;
      read_mask_reg <= 4'h0;
    end
    else if (freeze_reg)
    begin
      freeze_reg    <= ~all_read;
      read_mask_reg <= all_read ? 4'h0 : mask_add;
    end
    else if (hit_low1 | hit_low2)
    begin
      freeze_reg    <= 1'b1;
      read_mask_reg <= {2'h0, hit_low2, hit_low1};
    end
  end

  // Visible copy follows live results; a freeze pins only the remote-one and local entries; whole-degree reads need no order
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 5; i++)
        vis_reg[i] <= `AMS_RST_VALUE;
    end
    else
    begin
      for (int i = 0; i < 5; i++)
      begin
        if (!freeze_reg || !(i == 3 || i == 4))
          vis_reg[i] <= res_reg[i];
      end
    end
  end

  // Register read mux
  logic [7:0] rd_val;
  always_comb
  begin
    case (idx)
      `AMS_IDX_CFG_ONE:    rd_val = cfg_one_reg;
      `AMS_IDX_CFG_TWO:    rd_val = cfg_two_reg;
      `AMS_IDX_CFG_FOUR:   rd_val = cfg_four_reg;
      `AMS_IDX_PIN_MODE:   rd_val = pin_mode_reg;
      `AMS_IDX_FORMAT:     rd_val = format_reg;
      `AMS_IDX_LOW_ONE:    rd_val = {6'h00, vis_reg[3].lsb};
      `AMS_IDX_LOW_TWO:    rd_val = {6'h00, vis_reg[4].lsb};
      `AMS_IDX_ANALOG_INPUT_ONE_VAL:   rd_val = vis_reg[0].msb;
      `AMS_IDX_ANALOG_INPUT_TWO_VAL:   rd_val = vis_reg[1].msb;
      `AMS_IDX_SUPPLY_VAL: rd_val = vis_reg[2].msb;
      `AMS_IDX_REM1_VAL:   rd_val = vis_reg[3].msb;
      `AMS_IDX_LOCAL_VAL:  rd_val = vis_reg[4].msb;
      default:             rd_val = 8'h00;
    endcase
    if (adr_i[11:10] != 2'h0)
      rd_val = 8'h00;
  end

  // Bus slave: ack one cycle after the request, data latched with it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req & ~ack_reg & ~we_i)
        dat_reg <= {24'h00_0000, rd_val};
    end
  end

  // Configuration writes take effect on the acknowledging edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_one_reg  <= `AMS_RST_CFG;
      cfg_two_reg  <= `AMS_RST_CFG;
      cfg_four_reg <= `AMS_RST_CFG;
      pin_mode_reg <= `AMS_RST_CFG;
      format_reg   <= `AMS_RST_CFG;
    end
    else if (wr_now)
    begin
      case (idx)
        `AMS_IDX_CFG_ONE:  cfg_one_reg  <= dat_i[7:0];
        `AMS_IDX_CFG_TWO:  cfg_two_reg  <= dat_i[7:0];
        `AMS_IDX_CFG_FOUR: cfg_four_reg <= dat_i[7:0];
        `AMS_IDX_PIN_MODE: pin_mode_reg <= dat_i[7:0];
        `AMS_IDX_FORMAT:   format_reg   <= dat_i[7:0];
        default:           ;
      endcase
    end
  end

  assign dat_o      = dat_reg;
  assign ack_o      = ack_reg;
  assign adc_req_o  = req_reg;
  assign adc_chan_o = chan_reg;

  // Busy flag registered so it never glitches
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      busy_o <= 1'b0;
    else
      busy_o <= (state_next != ams_pkg::ST_IDLE);
  end

endmodule : ams_sequencer
`default_nettype wire

// file: test/ams_seq_chk.sv
// Port-level assertions for the monitor sequencer
`default_nettype none
module ams_seq_chk (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               cyc_i,
  input wire logic               stb_i,
  input wire logic               we_i,
  input wire logic [31:0]        dat_o,
  input wire logic               ack_o,
  input wire logic               adc_req_o,
  input wire ams_pkg::ams_chan_t adc_chan_o,
  input wire logic               adc_ack_i,
  input wire logic               busy_o
);
  logic pend_reg;
  logic pend_next;

  // Pending sample; idle clears it so an aborted slot cannot leave it stuck
  assign pend_next = adc_req_o ? 1'b1 : ((adc_ack_i || !busy_o) ? 1'b0 : pend_reg);

  // Pending flag register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pend_reg <= 1'b0;
    else
      pend_reg <= pend_next;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Bus handshake and read data shape
  a_ack_one_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged in one cycle");
  a_ack_drops: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  a_read_upper_zero: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  // Converter request discipline
  a_req_single_pulse: assert property (adc_req_o |=> !adc_req_o)
    else $error("sample request longer than one cycle");
  a_req_while_busy: assert property (adc_req_o |-> busy_o)
    else $error("sample request while idle");
  a_req_one_pending: assert property (adc_req_o |-> !pend_reg)
    else $error("new sample requested before answer");
  a_chan_slot_start: assert property ($changed(adc_chan_o) && busy_o && $past(busy_o)
    |-> adc_req_o)
    else $error("channel changed inside a slot");

  c_second_diode: cover property (adc_req_o && adc_chan_o == ams_pkg::CH_REM2);
  c_reg_write: cover property (ack_o && we_i);
  c_sample_answer: cover property (adc_ack_i && pend_reg);
endmodule : ams_seq_chk

bind ams_sequencer ams_seq_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o,
  .ack_o, .adc_req_o, .adc_chan_o, .adc_ack_i, .busy_o);
`default_nettype wire

// file: test/ams_adc_model.sv
// Behavioural converter front end answering sample requests
`default_nettype none
module ams_adc_model (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               req_i,
  input  wire ams_pkg::ams_chan_t chan_i,
  input  wire logic               slow_i,
  input  wire logic               wobble_i,
  input  wire logic [9:0]         bias_i,
  output logic                    ack_o,
  output logic      [9:0]         data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt;
  logic       odd;
  logic [2:0] ch;

  // Answer after two or seven cycles; data shows noise whenever not valid
  always_ff @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    data_o <= ~data_o;
    if (rst_i)
    begin
      cnt <= 0;
      odd <= 1'b0;
      data_o <= 10'h000;
    end
    else if (req_i)
    begin
      cnt <= slow_i ? 7 : 2;
      ch <= chan_i;
    end
    else if (cnt == 1)
    begin
      ack_o <= 1'b1;
      data_o <= bias_i + {1'b0, ch, 6'h00} + ((wobble_i && odd) ? 10'h008 : 10'h000);
      odd <= ~odd;
      cnt <= 0;
    end
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
endmodule : ams_adc_model
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the monitor sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, adc_req_o;
  logic               adc_ack_i, busy_o, slow, wob;
  logic [11:0]        adr_i;
  logic [3:0]         sel_i;
  logic [31:0]        dat_i, dat_o;
  logic [9:0]         adc_data_i, bias;
  ams_pkg::ams_chan_t adc_chan_o, g;
  int                 err_count, samples_checked, cyc_cnt, t0, sp;
  logic [7:0]         x;

  ams_sequencer #(.T_LOC_ON_CYC(200), .T_REM_ON_CYC(240), .T_AIN_ON_CYC(200),
    .T_VCC_ON_CYC(200), .T_LOC_OFF_CYC(60), .T_REM_OFF_CYC(90), .T_AIN_OFF_CYC(60),
    .T_VCC_OFF_CYC(60), .T_SINGLE_CYC(80), .TH10K_GAIN(8'h80), .TH10K_OFFSET(10'h010))
  DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .adc_req_o, .adc_chan_o, .adc_ack_i, .adc_data_i, .busy_o);

  ams_adc_model u_adc (.clk_i, .rst_i, .req_i(adc_req_o), .chan_i(adc_chan_o),
    .slow_i(slow), .wobble_i(wob), .bias_i(bias), .ack_o(adc_ack_i), .data_o(adc_data_i));

  task automatic complete_run;
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic fail(input string m);
    err_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
      fail($sformatf("reg got %h exp %h", got, exp));
  endtask : cmp8

  task automatic cmpc(input ams_pkg::ams_chan_t got, input ams_pkg::ams_chan_t exp);
    samples_checked++;
    if (got !== exp)
      fail($sformatf("chan got %0d exp %0d", got, exp));
  endtask : cmpc

  // Slot spans may carry a few cycles of commit overhead
  task automatic cmp_span(input int v, input int lo);
    samples_checked++;
    if (v < lo || v > lo + 4)
      fail($sformatf("span %0d exp %0d", v, lo));
  endtask : cmp_span

  // One classic Wishbone cycle; held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {2'b00, idx, 2'b00};
    dat_i <= {24'h00_0000, wd};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    if (n >= 20)
      fail("no ack");
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b1, idx, d, r);
  endtask : wr

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    xfer(1'b0, idx, 8'h00, r);
    cmp8(r, exp);
  endtask : rchk

  task automatic wait_req(output ams_pkg::ams_chan_t c, output int t);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (adc_req_o !== 1'b1 && n < 3000);
    if (n >= 3000)
      fail("no sample request");
    c = adc_chan_o;
    t = int'($time / 40);
  endtask : wait_req

  task automatic wait_chan(input ams_pkg::ams_chan_t c, output int t);
    ams_pkg::ams_chan_t h;
    int n;
    n = 0;
    do
    begin
      wait_req(h, t);
      n++;
    end
    while (h !== c && n < 200);
  endtask : wait_chan

  // Two full passes of slot c, so its stored result is fresh; returns slot span
  task automatic settle(input ams_pkg::ams_chan_t c, input ams_pkg::ams_chan_t nx,
                        output int span);
    int ta, tb;
    repeat (2)
    begin
      wait_chan(c, ta);
      wait_chan(nx, tb);
    end
    span = tb - ta;
    repeat (4) @(posedge clk_i);
  endtask : settle

  // Cycle ceiling cuts a hang short
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 60000)
    begin
      fail("timeout");
      complete_run();
    end
  end

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Main sequence: reset, then each scenario in turn
  initial
  begin
    {cyc_i, stb_i, we_i, slow, wob} = 5'h00;
    adr_i = 12'h000;
    sel_i = 4'h1;
    dat_i = 32'h0000_0000;
    bias = 10'h043;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(8'h00, 8'h00);
    rchk(8'h01, 8'h00);
    rchk(8'h03, 8'h00);
    wr(8'h3F, 8'hFF);
    rchk(8'h3F, 8'h00);
    sel_i <= 4'h0;
    wr(8'h01, 8'hFF);
    sel_i <= 4'h1;
    rchk(8'h01, 8'h00);
    // Round robin, averaging off
    wr(8'h01, 8'h10);
    wr(8'h00, 8'h01);
    for (int i = 0; i < 10; i++)
    begin
      wait_req(g, sp);
      if (i == 3) t0 = sp;
      if (i == 4) cmp_span(sp - t0, 90);
      cmpc(g, ams_pkg::ams_chan_t'(i % 5));
    end
    repeat (4) @(posedge clk_i);
    rchk(8'h0A, 8'h10);
    rchk(8'h0B, 8'h20);
    rchk(8'h0C, 8'h30);
    rchk(8'h08, 8'h03);
    rchk(8'h09, 8'h03);
    rchk(8'h0D, 8'h40);
    rchk(8'h0E, 8'h50);
    // Averaging on, slow converter, alternating samples
    slow <= 1'b1;
    wob <= 1'b1;
    wr(8'h01, 8'h00);
    settle(ams_pkg::CH_REM1, ams_pkg::CH_LOCAL, sp);
    cmp_span(sp, 240);
    rchk(8'h08, 8'h03);
    rchk(8'h0D, 8'h41);
    rchk(8'h09, 8'h03);
    rchk(8'h0E, 8'h51);
    wr(8'h01, 8'h10);
    settle(ams_pkg::CH_REM1, ams_pkg::CH_LOCAL, sp);
    xfer(1'b0, 8'h08, 8'h00, x);
    xfer(1'b0, 8'h0D, 8'h00, x);
    cmp8({7'h00, x === 8'h40 || x === 8'h42}, 8'h01);
    rchk(8'h09, 8'h03);
    xfer(1'b0, 8'h0E, 8'h00, x);
    cmp8({7'h00, x === 8'h50 || x === 8'h52}, 8'h01);
    // Freeze across a data change
    slow <= 1'b0;
    wob <= 1'b0;
    settle(ams_pkg::CH_LOCAL, ams_pkg::CH_ANALOG_INPUT_ONE, sp);
    rchk(8'h08, 8'h03);
    bias <= 10'h083;
    settle(ams_pkg::CH_LOCAL, ams_pkg::CH_ANALOG_INPUT_ONE, sp);
    rchk(8'h0B, 8'h30);
    rchk(8'h0D, 8'h40);
    rchk(8'h09, 8'h03);
    rchk(8'h0E, 8'h50);
    repeat (4) @(posedge clk_i);
    rchk(8'h0D, 8'h50);
    // Second diode in place of both inputs
    wr(8'h04, 8'h04);
    settle(ams_pkg::CH_REM2, ams_pkg::CH_SUPPLY, sp);
    cmp_span(sp, 90);
    for (int i = 0; i < 4; i++)
    begin
      wait_req(g, sp);
      cmpc(g, ams_pkg::ams_chan_t'(i == 3 ? 2 : 3 + i));
    end
    rchk(8'h0A, 8'h70);
    wr(8'h04, 8'h00);
    // Single-channel select codes 0 to 5, then back to round robin
    for (int s = 0; s < 6; s++)
    begin
      wr(8'h03, 8'h08 | 8'(s));
      wait_req(g, t0);
      wait_req(g, t0);
      wait_req(g, sp);
      cmpc(g, ams_pkg::ams_chan_t'(s));
      cmp_span(sp - t0, 80);
    end
    wr(8'h03, 8'h00);
    wait_req(g, sp);
    cmpc(g, ams_pkg::CH_ANALOG_INPUT_ONE);
    // Thermistor scaling, both normalisations
    wr(8'h04, 8'h01);
    wr(8'h01, 8'h11);
    settle(ams_pkg::CH_ANALOG_INPUT_ONE, ams_pkg::CH_ANALOG_INPUT_TWO, sp);
    rchk(8'h0A, 8'h45);
    wr(8'h01, 8'h10);
    settle(ams_pkg::CH_ANALOG_INPUT_ONE, ams_pkg::CH_ANALOG_INPUT_TWO, sp);
    rchk(8'h0A, 8'h20);
    wr(8'h04, 8'h00);
    // Offset-binary format
    wr(8'h05, 8'h01);
    settle(ams_pkg::CH_LOCAL, ams_pkg::CH_ANALOG_INPUT_ONE, sp);
    rchk(8'h09, 8'h03);
    rchk(8'h0E, 8'hA0);
    rchk(8'h08, 8'h03);
    rchk(8'h0D, 8'h90);
    // Stop: no further requests, sequencer idle
    wr(8'h00, 8'h00);
    repeat (4) @(posedge clk_i);
    t0 = 0;
    repeat (300)
    begin
      @(posedge clk_i);
      if (adc_req_o !== 1'b0) t0++;
    end
    cmp8(8'(t0), 8'h00);
    cmp8({7'h00, busy_o}, 8'h00);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
